// ---- fcd_decode.sv ----
// opcode decoder: classifies one instruction word into the three handled operations
`timescale 1ns/1ns
module fcd_decode
    import fcd_pkg::*;
(
    input wire logic [11:0] instr_i,
    output fcd_op_t op_o,
    output logic dest_file_o,
    output logic [4:0] addr_o
);
    wire logic [5:0] opc = instr_i[OPC_HI:OPC_LO];
    wire logic is_comp = (opc == OPC_COMPLEMENT);
    wire logic is_dec = (opc == OPC_DECREMENT);
    wire logic is_dsz = (opc == OPC_DEC_SKIP);

    assign op_o = is_comp ? FCD_OP_COMPLEMENT :
                  is_dec ? FCD_OP_DECREMENT :
                  is_dsz ? FCD_OP_DEC_SKIP : FCD_OP_NONE;
    assign dest_file_o = instr_i[DEST_BIT];
    assign addr_o = instr_i[ADDR_W-1:0];
endmodule

// ---- fcd_exec.sv ----
// execute stage for complement, decrement and decrement-skip-if-zero on file registers
// How it works
// [RULE1] complement opcode inverts the addressed file register value to the destination
// [RULE2] destination bit clear writes accumulator, set writes the file register back
// [RULE3] decrement opcode subtracts one modulo 256 and routes by destination bit
// [RULE4] decrement-skip subtracts one, routes by destination, leaves all status flags alone
// [RULE5] zero decrement-skip result squashes the prefetched next instruction into a no-op
// [RULE6] decrement-skip takes one cycle, two if zero; the others one cycle
// [RULE7] for I/O port sources the pin levels are the operand, not the latch
// [RULE8] complement and decrement update zero flag; carry and digit carry untouched
`timescale 1ns/1ns
module fcd_exec
    import fcd_pkg::*;
(
    // clock and control
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // instruction from fetch, one per cycle while valid
    input wire logic instr_valid_i,
    input wire logic [11:0] instr_i,
    // file register read port, same clock, and port pins from outside the clock domain
    output logic [4:0] file_raddr_o,
    input wire logic [7:0] file_rdata_i,
    input wire logic file_is_port_i,
    input wire logic [7:0] port_pins_i,
    // result write-back
    output fcd_wb_t wb_o,
    output logic zero_flag_we_o,
    output logic zero_flag_o,
    // squash indication: current slot runs as no-operation
    output logic no_operation_slot_o,
    output logic executed_o
);
    fcd_op_t op;
    logic dest_file;
    logic [4:0] addr;
    fcd_state_t state_q, state_d;
    fcd_wb_t wb_q, wb_d;
    logic zwe_q, zval_q, exec_q, zwe_d, zval_d, exec_d;
    logic [7:0] pins_s1_q, pins_s2_q;

    fcd_decode u_dec (
        .instr_i(instr_i),
        .op_o(op),
        .dest_file_o(dest_file),
        .addr_o(addr)
    );

    // pins come from outside the clock domain, so two flops first
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            pins_s1_q <= ZERO_BYTE;
            pins_s2_q <= ZERO_BYTE;
        end else if (clk_en_i) begin
            pins_s1_q <= port_pins_i;
            pins_s2_q <= pins_s1_q;
        end
    end

    assign file_raddr_o = addr;
    wire logic [7:0] operand = file_is_port_i ? pins_s2_q : file_rdata_i; // RULE7
    wire logic [7:0] comp_res = ~operand; // RULE1
    wire logic [7:0] dec_res = operand - DEC_STEP; // RULE3
    wire logic squashing = (state_q == FCD_ST_SQUASH);
    wire logic live = instr_valid_i && !squashing && (op != FCD_OP_NONE);
    wire logic [7:0] result = (op == FCD_OP_COMPLEMENT) ? comp_res : dec_res;
    wire logic res_zero = (result == ZERO_BYTE);
    wire logic updates_z = (op == FCD_OP_COMPLEMENT) || (op == FCD_OP_DECREMENT); // RULE4 RULE8

    always_comb begin
        state_d = state_q;
        if (instr_valid_i) begin
            case (state_q)
                FCD_ST_RUN: begin
                    if (live && op == FCD_OP_DEC_SKIP && res_zero) begin
                        state_d = FCD_ST_SQUASH; // RULE5 RULE6
                    end
                end
                FCD_ST_SQUASH: begin
                    state_d = FCD_ST_RUN;
                end
                default: begin
                    state_d = FCD_ST_RUN;
                end
            endcase
        end
    end

    always_comb begin
        wb_d.we_accum = live && !dest_file; // RULE2
        wb_d.we_file = live && dest_file; // RULE2
        wb_d.addr = addr;
        wb_d.data = result;
        zwe_d = live && updates_z; // RULE8
        zval_d = res_zero;
        exec_d = live;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_q <= FCD_ST_RUN;
            wb_q <= '0;
            zwe_q <= 1'b0;
            zval_q <= ZERO_FLAG_RST;
            exec_q <= 1'b0;
        end else if (clk_en_i) begin
            state_q <= state_d;
            wb_q <= wb_d;
            zwe_q <= zwe_d;
            zval_q <= zval_d;
            exec_q <= exec_d;
        end
    end

    assign wb_o = wb_q;
    assign zero_flag_we_o = zwe_q;
    assign zero_flag_o = zval_q;
    assign no_operation_slot_o = squashing && instr_valid_i; // RULE5
    assign executed_o = exec_q;

    property p_comp_value;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && live && op == FCD_OP_COMPLEMENT) |=> (wb_o.data == ~$past(operand));
    endproperty
    a_comp_value: assert property (p_comp_value) else $error("complement result wrong"); // RULE1

    property p_dest;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && live) |=> (wb_o.we_file == $past(dest_file)) && (wb_o.we_accum != wb_o.we_file);
    endproperty
    a_dest: assert property (p_dest) else $error("destination select wrong"); // RULE2

    property p_dec_value;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && live && op != FCD_OP_COMPLEMENT) |=> (wb_o.data == $past(operand) - DEC_STEP);
    endproperty
    a_dec_value: assert property (p_dec_value) else $error("decrement result wrong"); // RULE3

    property p_dsz_noflag;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && live && op == FCD_OP_DEC_SKIP) |=> !zero_flag_we_o;
    endproperty
    a_dsz_noflag: assert property (p_dsz_noflag) else $error("skip op touched flags"); // RULE4

    property p_squash;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && instr_valid_i && live && op == FCD_OP_DEC_SKIP && res_zero)
            ##1 (clk_en_i && instr_valid_i) |-> (no_operation_slot_o && !live);
    endproperty
    a_squash: assert property (p_squash) else $error("next instruction not squashed"); // RULE5

    property p_one_cycle;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && instr_valid_i && live && !(op == FCD_OP_DEC_SKIP && res_zero)) |=> state_q == FCD_ST_RUN;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("extra cycle taken"); // RULE6

    property p_pins;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && live && file_is_port_i && op == FCD_OP_COMPLEMENT) |=> wb_o.data == ~$past(pins_s2_q);
    endproperty
    a_pins: assert property (p_pins) else $error("port operand not from pins"); // RULE7

    property p_zflag;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && live && updates_z) |=> zero_flag_we_o && (zero_flag_o == (wb_o.data == ZERO_BYTE));
    endproperty
    a_zflag: assert property (p_zflag) else $error("zero flag wrong"); // RULE8

    property p_freeze;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !clk_en_i |=> $stable(wb_o) && $stable(zero_flag_o) && $stable(zero_flag_we_o) && $stable(executed_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("outputs moved while enable low"); // RULE6

    property p_no_write;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && !live) |=> !wb_o.we_accum && !wb_o.we_file && !executed_o && !zero_flag_we_o;
    endproperty
    a_no_write: assert property (p_no_write) else $error("write from a slot that was not live"); // RULE5

    property p_exec;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && live) |=> executed_o;
    endproperty
    a_exec: assert property (p_exec) else $error("executed pulse missing"); // RULE6

    property p_addr;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && live) |=> (wb_o.addr == $past(addr));
    endproperty
    a_addr: assert property (p_addr) else $error("write-back address wrong"); // RULE2

    property p_skip_arm;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && live && op == FCD_OP_DEC_SKIP && res_zero) |=> squashing;
    endproperty
    a_skip_arm: assert property (p_skip_arm) else $error("zero skip did not arm squash"); // RULE5

    property p_squash_wait;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && squashing && !instr_valid_i) |=> squashing;
    endproperty
    a_squash_wait: assert property (p_squash_wait) else $error("squash dropped before next instruction"); // RULE5

    property p_squash_end;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && squashing && instr_valid_i) |=> !squashing;
    endproperty
    a_squash_end: assert property (p_squash_end) else $error("squash lasted more than one slot"); // RULE6

    property p_dec_zero;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && live && op == FCD_OP_DECREMENT && operand == DEC_STEP) |=> zero_flag_o;
    endproperty
    a_dec_zero: assert property (p_dec_zero) else $error("decrement to zero left flag clear"); // RULE8

    c_comp: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) exec_q && wb_o.we_file && zero_flag_we_o);
    c_skip: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) no_operation_slot_o);
    c_dec_acc: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) wb_o.we_accum && zero_flag_o);
    c_freeze: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) !clk_en_i && exec_q);
    c_port: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) live && file_is_port_i);
endmodule

// ---- fcd_file_model.sv ----
// file register datapath model facing the execute block
`timescale 1ns/1ns
module fcd_file_model
    import fcd_pkg::*;
(
    // clock
    input wire logic ref_clk_i,
    // read port and write-back
    input wire logic [4:0] file_raddr_i,
    input wire fcd_wb_t wb_i,
    output logic [7:0] file_rdata_o
);
    logic [7:0] mem_q [32];
    // each register starts at its own address so expected results stay easy to work out
    initial for (int a = 0; a < 32; a++) mem_q[a] = 8'(a);
    assign file_rdata_o = mem_q[file_raddr_i];
    always @(posedge ref_clk_i) if (wb_i.we_file) mem_q[wb_i.addr] <= wb_i.data;
endmodule

// ---- fcd_pkg.sv ----
// package for the file-register complement and decrement execute block
package fcd_pkg;
    localparam int INSTR_W = 12;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int OPC_HI = 11;
    localparam int OPC_LO = 6;
    localparam int DEST_BIT = 5;
    localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
    localparam logic [5:0] OPC_DECREMENT = 6'h03;
    localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
    localparam logic [7:0] DEC_STEP = 8'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [11:0] NOP_WORD = 12'h000;
    localparam logic ZERO_FLAG_RST = 1'b0;

    typedef enum logic [1:0] {
        FCD_OP_NONE = 2'b00,
        FCD_OP_COMPLEMENT = 2'b01,
        FCD_OP_DECREMENT = 2'b10,
        FCD_OP_DEC_SKIP = 2'b11
    } fcd_op_t;

    typedef enum logic [0:0] {
        FCD_ST_RUN = 1'b0,
        FCD_ST_SQUASH = 1'b1
    } fcd_state_t;

    typedef struct packed {
        logic we_accum;
        logic we_file;
        logic [4:0] addr;
        logic [7:0] data;
    } fcd_wb_t;
endpackage

// ---- tb.sv ----
// self-checking bench for the complement and decrement execute block
`timescale 1ns/1ns
module tb
    import fcd_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic vld = 1'b0;
    logic clk_en = 1'b1;
    logic [11:0] instr = NOP_WORD;
    logic is_port = 1'b0;
    logic [7:0] pins = 8'h00;
    logic [4:0] raddr;
    logic [7:0] rdata;
    fcd_wb_t wb;
    logic zwe, zf, nos, ex;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    always #50 ref_clk = ~ref_clk;
    fcd_exec fcd_exec_i(.ref_clk_i(ref_clk), .reset_n_i(reset_n), .clk_en_i(clk_en), .instr_valid_i(vld),
        .instr_i(instr), .file_raddr_o(raddr), .file_rdata_i(rdata), .file_is_port_i(is_port),
        .port_pins_i(pins), .wb_o(wb), .zero_flag_we_o(zwe), .zero_flag_o(zf),
        .no_operation_slot_o(nos), .executed_o(ex));
    fcd_file_model fcd_file_model_i(.ref_clk_i(ref_clk), .file_raddr_i(raddr), .wb_i(wb), .file_rdata_o(rdata));
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // flags: squashed, accumulator write, file write, zero flag write, executed
    task automatic op(input logic [11:0] w, input logic [4:0] flags, input logic [7:0] d, input logic z);
        @(negedge ref_clk);
        vld = 1'b1;
        instr = w;
        #1 chk(16'(nos), 16'(flags[4]));
        @(negedge ref_clk);
        vld = 1'b0;
        chk(16'({wb.we_accum, wb.we_file, zwe, ex}), 16'(flags[3:0]));
        if (flags[3] | flags[2]) chk(16'({wb.addr, wb.data}), 16'({w[4:0], d}));
        if (flags[1]) chk(16'(zf), 16'(z));
    endtask
    task automatic t_comp();
        op(12'h243, 5'b01011, 8'hFC, 1'b0);
        op(12'h263, 5'b00111, 8'hFC, 1'b0);
        // accumulator result must reflect the value written back just before
        op(12'h243, 5'b01011, 8'h03, 1'b0);
    endtask
    task automatic t_dec();
        op(12'h0E0, 5'b00111, 8'hFF, 1'b0);
        op(12'h0C1, 5'b01011, 8'h00, 1'b1);
        op(12'h240, 5'b01011, 8'h00, 1'b1);
    endtask
    task automatic t_skip();
        op(12'h2E2, 5'b00101, 8'h01, 1'b0);
        op(12'h2C2, 5'b01001, 8'h00, 1'b0);
        op(12'h261, 5'b10000, 8'h00, 1'b0);
        // register 1 still holds 01 because the squashed write never landed
        op(12'h241, 5'b01011, 8'hFE, 1'b0);
        op(12'h1E1, 5'b00000, 8'h00, 1'b0);
        // back to back: the slot right after a zero skip must be dropped
        @(negedge ref_clk);
        vld = 1'b1;
        instr = 12'h2C2;
        @(negedge ref_clk);
        instr = 12'h261;
        chk(16'({wb.we_accum, wb.we_file, zwe, ex}), 16'h9);
        #1 chk(16'(nos), 16'h1);
        @(negedge ref_clk);
        vld = 1'b0;
        chk(16'({wb.we_accum, wb.we_file, zwe, ex}), 16'h0);
        op(12'h241, 5'b01011, 8'hFE, 1'b0);
    endtask
    task automatic t_port();
        @(negedge ref_clk);
        is_port = 1'b1;
        pins = 8'h5A;
        // pins pass a two-stage synchroniser, so let them settle first
        repeat (3) @(negedge ref_clk);
        op(12'h246, 5'b01011, 8'hA5, 1'b0);
        is_port = 1'b0;
    endtask
    task automatic t_hold();
        @(negedge ref_clk);
        vld = 1'b1;
        instr = 12'h245;
        @(negedge ref_clk);
        vld = 1'b0;
        clk_en = 1'b0;
        @(negedge ref_clk);
        // enable low: the last result must stand instead of dropping
        chk(16'({wb.we_accum, wb.we_file, zwe, ex}), 16'hB);
        vld = 1'b1;
        instr = 12'h265;
        @(negedge ref_clk);
        // a frozen core takes nothing, so this write-back request is lost
        chk(16'({wb.we_accum, wb.we_file, zwe, ex}), 16'hB);
        chk(16'({wb.addr, wb.data}), 16'({5'h05, 8'hFA}));
        vld = 1'b0;
        clk_en = 1'b1;
        @(negedge ref_clk);
        chk(16'({wb.we_accum, wb.we_file, zwe, ex}), 16'h0);
        op(12'h245, 5'b01011, 8'hFA, 1'b0);
    endtask
    task automatic t_reset();
        op(12'h2C2, 5'b01001, 8'h00, 1'b0);
        // squash is armed now; a mid-run reset must clear it and the write enables, zero flag and executed pulse
        reset_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(16'({wb.we_accum, wb.we_file, zwe, zf, ex}), 16'h0);
        reset_n = 1'b1;
        op(12'h241, 5'b01011, 8'hFE, 1'b0);
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        reset_n = 1'b1;
        t_comp();
        t_dec();
        t_skip();
        t_port();
        t_hold();
        t_reset();
        report_and_stop();
    end
endmodule
